/* logic/etc_top.sv */
`timescale 1ns/10ps
// Contract
// - Exposure equals raw multiplier times time base.
// - Time base resets to 20 microseconds.
// - Time base programmable in 1 microsecond steps.
// - Absolute value writable in 1 microsecond steps.
// - Absolute write derives raw from current base.
// - Non-multiple absolute rounds to nearest multiple.
// - Raw or base change updates absolute readback.
// - Settable duration capped at variant maximum; raw 1 may reach 10000000 and the sequencer times raw times base uncapped.
// - Raw 1 with base 10000000 gives 10000000.
// - Auto value not restricted to base multiples.
// - Pulse width mode disables auto exposure.
module etc_top
   import etc_pkg::*;
#(
   parameter logic [23:0] MAX_US = ETC_MAX_DEF,   // Variant maximum exposure.
   parameter logic [23:0] MIN_US = ETC_MIN_DEF    // Variant minimum exposure.
)(
   input  wire logic        pclk,          // Clock, 25 MHz.
   input  wire logic        presetn,       // Asynchronous reset, active low.
   input  wire logic        ce,            // Clock enable, freezes all state when low.
   input  wire logic        psel,          // APB select.
   input  wire logic        penable,       // APB access phase.
   input  wire logic        pwrite,        // APB direction.
   input  wire logic [7:0]  paddr,         // APB byte address.
   input  wire logic [31:0] pwdata,        // APB write data.
   output logic [31:0]      prdata,        // APB read data.
   output logic             pready,        // APB ready.
   output logic             pslverr,       // APB error.
   input  wire logic        trigger_pin,   // Exposure trigger from a pin.
   output logic             exposure_active // High while the sensor exposes.
);
   // ----------------------------------------------------------------
   // State declarations.
   // ----------------------------------------------------------------
   logic [23:0] raw_reg;        // Raw multiplier.
   logic [23:0] base_reg;       // Time base in microseconds.
   logic [23:0] abs_reg;        // Effective duration readback.
   logic [23:0] auto_reg;       // Auto-adjusted duration.
   logic        pulse_reg;      // Pulse width exposure mode.
   logic        auto_en_reg;    // Auto exposure requested.
   logic [2:0]  trig_sync;      // Pin synchroniser.
   logic        trig_lvl;       // Filtered trigger level.
   logic        trig_prev;      // Trigger level one cycle ago.
   logic [4:0]  tick_cnt;       // Cycle counter within a microsecond.
   logic        tick;           // One-cycle microsecond strobe.
   logic [23:0] base_cnt;       // Microseconds into current base period.
   logic [23:0] raw_cnt;        // Base periods completed.
   logic        div_start;      // Conversion request.
   logic        div_busy;       // Conversion running.
   logic        div_done;       // Conversion finished.
   logic [24:0] div_quot;       // Rounded quotient.
   logic [24:0] div_num;        // Numerator including half a base.
   logic [23:0] abs_wr;         // Written absolute value after capping.
   logic        acc;            // Access phase completing this edge.
   logic        wr_ok;          // Write takes effect.
   logic        auto_active;    // Auto value in effect.
   logic        start_req;      // Software asked for an exposure.

   typedef enum logic [2:0] {
      ETC_IDLE  = 3'b001,
      ETC_TIMED = 3'b010,
      ETC_PULSE = 3'b100
   } etc_state_type;
   etc_state_type state;        // Exposure sequencer state.

   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   // Saturating product; a single raw step may reach the absolute ceiling
   // even on a variant with a smaller maximum.
   function automatic logic [23:0] etc_product(input logic [23:0] r, input logic [23:0] b,
                                               input logic [23:0] lim);
      logic [47:0] p;
      logic [23:0] cap;
      p   = r * b;
      cap = (r == ETC_RAW_MIN && b > lim) ? ETC_ABS_CEIL : lim;
      if (p > {24'h000000, cap}) begin
         etc_product = cap;
      end else begin
         etc_product = p[23:0];
      end
   endfunction

   // Clamp a value into a closed range.
   function automatic logic [23:0] etc_clamp(input logic [23:0] v, input logic [23:0] lo,
                                             input logic [23:0] hi);
      if (v < lo) begin
         etc_clamp = lo;
      end else if (v > hi) begin
         etc_clamp = hi;
      end else begin
         etc_clamp = v;
      end
   endfunction

   // ----------------------------------------------------------------
   // APB slave.
   // ----------------------------------------------------------------
   assign acc    = psel && penable && pready;
   assign wr_ok  = acc && pwrite && !pslverr;
   assign abs_wr = etc_clamp(pwdata[23:0], ETC_RAW_MIN, MAX_US);
   assign div_num = {1'b0, abs_wr} + {2'b00, base_reg[23:1]};
   assign div_start = wr_ok && paddr == ETC_OFS_ABS;
   assign start_req = wr_ok && paddr == ETC_OFS_CTRL && pwdata[ETC_CTRL_START];

   // Ready rises one cycle into the access phase, so every transfer takes
   // exactly three cycles; the error flag and read data stand with it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (ce) begin
         pready  <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && penable && !pready) begin
            if (paddr == ETC_OFS_CTRL) begin
               prdata <= {29'h0, auto_en_reg, pulse_reg, 1'b0};
            end else if (paddr == ETC_OFS_RAW) begin
               prdata <= {8'h00, raw_reg};
            end else if (paddr == ETC_OFS_BASE) begin
               prdata <= {8'h00, base_reg};
            end else if (paddr == ETC_OFS_ABS) begin
               prdata <= {8'h00, abs_reg};
               pslverr <= pwrite && div_busy;   // A second conversion cannot queue.
            end else if (paddr == ETC_OFS_AUTO) begin
               prdata <= {8'h00, auto_reg};
            end else if (paddr == ETC_OFS_STATUS) begin
               prdata <= {28'h0, abs_reg < MIN_US, auto_active, state != ETC_IDLE, div_busy};
               pslverr <= pwrite;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // Control bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_reg   <= 1'b0;
         auto_en_reg <= 1'b0;
      end else if (ce && wr_ok && paddr == ETC_OFS_CTRL) begin
         pulse_reg   <= pwdata[ETC_CTRL_PULSE];
         auto_en_reg <= pwdata[ETC_CTRL_AUTO];
      end
   end

   // Auto function forbidden while the trigger width sets the exposure.
   assign auto_active = auto_en_reg && !pulse_reg;

   // Time base; zero would give the divider an all-ones quotient, so it is clamped to one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_reg <= ETC_BASE_RST;
      end else if (ce && wr_ok && paddr == ETC_OFS_BASE) begin
         base_reg <= etc_clamp(pwdata[23:0], ETC_RAW_MIN, ETC_ABS_CEIL);
      end
   end

   // Raw multiplier, written directly or by the absolute conversion.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_reg <= ETC_RAW_RST;
      end else if (ce) begin
         if (div_done) begin
            raw_reg <= etc_clamp(div_quot[24] ? ETC_RAW_MAX : div_quot[23:0],
                                 ETC_RAW_MIN, ETC_RAW_MAX);
         end else if (wr_ok && paddr == ETC_OFS_RAW) begin
            raw_reg <= etc_clamp(pwdata[23:0], ETC_RAW_MIN, ETC_RAW_MAX);
         end
      end
   end

   // Readback follows the product, so a rounded absolute write reads back
   // as the reachable multiple two cycles after the conversion ends.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abs_reg <= ETC_ABS_RST;
      end else if (ce) begin
         abs_reg <= etc_product(raw_reg, base_reg, MAX_US);
      end
   end

   // Auto value is taken as written, any microsecond value from 1 up to the cap.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_reg <= ETC_AUTO_RST;
      end else if (ce && wr_ok && paddr == ETC_OFS_AUTO) begin
         auto_reg <= etc_clamp(pwdata[23:0], ETC_RAW_MIN, MAX_US);
      end
   end

   etc_div u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .start    (div_start),
      .dividend (div_num),
      .divisor  (base_reg),
      .busy     (div_busy),
      .done     (div_done),
      .quot     (div_quot)
   );

   // ----------------------------------------------------------------
   // Trigger pin and microsecond tick.
   // ----------------------------------------------------------------
   // Three stages; the level changes only when the last two agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_sync <= '0;
         trig_lvl  <= 1'b0;
         trig_prev <= 1'b0;
      end else if (ce) begin
         trig_sync <= {trig_sync[1:0], trigger_pin};
         trig_prev <= trig_lvl;
         if (trig_sync[2] == trig_sync[1]) begin
            trig_lvl <= trig_sync[2];
         end
      end
   end

   // Free-running microsecond strobe.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else if (ce) begin
         tick     <= tick_cnt == ETC_TICK_LAST;
         tick_cnt <= (tick_cnt == ETC_TICK_LAST) ? 5'h00 : tick_cnt + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Exposure sequencer.
   // ----------------------------------------------------------------
   // Timed exposures count whole base periods; with auto in effect the
   // base is one microsecond and the auto value is the count, so the
   // result need not be a base multiple. A start during an exposure is
   // ignored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state           <= ETC_IDLE;
         base_cnt        <= '0;
         raw_cnt         <= '0;
         exposure_active <= 1'b0;
      end else if (ce) begin
         case (state)
            ETC_IDLE: begin
               base_cnt <= '0;
               raw_cnt  <= '0;
               if (pulse_reg && trig_lvl && !trig_prev) begin
                  state           <= ETC_PULSE;
                  exposure_active <= 1'b1;
               end else if (!pulse_reg && start_req) begin
                  state           <= ETC_TIMED;
                  exposure_active <= 1'b1;
               end
            end
            ETC_TIMED: begin
               if (tick) begin
                  if (auto_active || base_cnt == base_reg - 24'h000001) begin
                     base_cnt <= '0;
                     raw_cnt  <= raw_cnt + 24'h000001;
                     if (raw_cnt + 24'h000001 >= (auto_active ? auto_reg : raw_reg)) begin
                        state           <= ETC_IDLE;
                        exposure_active <= 1'b0;
                     end
                  end else begin
                     base_cnt <= base_cnt + 24'h000001;
                  end
               end
            end
            ETC_PULSE: begin
               if (!trig_lvl) begin
                  state           <= ETC_IDLE;
                  exposure_active <= 1'b0;
               end
            end
            default: begin
               state           <= ETC_IDLE;
               exposure_active <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions; timing checks assume the clock enable stays high.
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   sequence s_abs_write;
      div_start;
   endsequence

   sequence s_conv_end;
      ##[1:30] div_done ##1 (raw_reg != 24'h000000);
   endsequence

   a_raw_in_range: assert property (raw_reg >= ETC_RAW_MIN && raw_reg <= ETC_RAW_MAX)
      else $error("raw multiplier out of range");
   a_abs_converts: assert property (s_abs_write |-> s_conv_end)
      else $error("absolute write did not convert");
   a_abs_tracks: assert property ($stable(raw_reg) && $stable(base_reg) |=>
                                  abs_reg == etc_product($past(raw_reg), $past(base_reg), MAX_US))
      else $error("absolute readback stale");
   a_abs_capped: assert property ($past(raw_reg) != ETC_RAW_MIN |-> abs_reg <= MAX_US)
      else $error("absolute exceeds variant maximum");
   a_ceiling_reach: assert property (raw_reg == ETC_RAW_MIN && base_reg == ETC_ABS_CEIL
                                     && $stable(raw_reg) && $stable(base_reg) |=> abs_reg == ETC_ABS_CEIL)
      else $error("ceiling exposure not reached");
   a_pulse_no_auto: assert property (pulse_reg |-> !auto_active)
      else $error("auto active in pulse width mode");
   a_tick_spacing: assert property (tick |=> !tick [*8] ##1 !tick [*8] ##1 !tick [*8] ##1 tick)
      else $error("microsecond tick period wrong");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held more than one cycle");
   a_base_rounds: assert property (div_done ##1 base_reg == ETC_RAW_MIN |-> ##1
                                   abs_reg == etc_product($past(raw_reg), ETC_RAW_MIN, MAX_US))
      else $error("unit base conversion not exact");
   a_expo_ends: assert property ($fell(exposure_active) && $past(state) == ETC_TIMED |->
                                 raw_cnt == ($past(auto_active) ? $past(auto_reg) : $past(raw_reg)))
      else $error("timed exposure length wrong");
endmodule // etc_top

/* logic/etc_pkg.sv */
package etc_pkg;
   // ----------------------------------------------------------------
   // Register map, byte addresses on the APB bus.
   // ----------------------------------------------------------------
   localparam logic [7:0]  ETC_OFS_CTRL   = 8'h00;   // Mode, auto enable, start.
   localparam logic [7:0]  ETC_OFS_RAW    = 8'h04;   // Raw multiplier.
   localparam logic [7:0]  ETC_OFS_BASE   = 8'h08;   // Time base in microseconds.
   localparam logic [7:0]  ETC_OFS_ABS    = 8'h0C;   // Absolute exposure in microseconds.
   localparam logic [7:0]  ETC_OFS_AUTO   = 8'h10;   // Auto-adjusted exposure in microseconds.
   localparam logic [7:0]  ETC_OFS_STATUS = 8'h14;   // Busy and activity flags.

   // ----------------------------------------------------------------
   // Field positions and widths.
   // ----------------------------------------------------------------
   localparam int          ETC_VAL_W      = 24;      // Width of every microsecond value.
   localparam int          ETC_CTRL_START = 0;       // Write one to start an exposure.
   localparam int          ETC_CTRL_PULSE = 1;       // Pulse width exposure mode select.
   localparam int          ETC_CTRL_AUTO  = 2;       // Auto exposure enable.
   localparam int          ETC_ST_BUSY    = 0;       // Conversion running.
   localparam int          ETC_ST_EXPO    = 1;       // Exposure in progress.
   localparam int          ETC_ST_AUTO    = 2;       // Auto value in effect.
   localparam int          ETC_ST_SHORT   = 3;       // Duration below variant minimum.

   // ----------------------------------------------------------------
   // Limits and values after reset.
   // ----------------------------------------------------------------
   localparam logic [23:0] ETC_RAW_MIN    = 24'h000001;  // Smallest raw multiplier.
   localparam logic [23:0] ETC_RAW_MAX    = 24'h989680;  // 10000000.
   localparam logic [23:0] ETC_ABS_CEIL   = 24'h989680;  // 10000000 us, reachable on every variant.
   localparam logic [23:0] ETC_MAX_DEF    = 24'h989680;  // Default variant maximum.
   localparam logic [23:0] ETC_MIN_DEF    = 24'h000018;  // Default variant minimum, 24 us.
   localparam logic [23:0] ETC_BASE_RST   = 24'h000014;  // 20 us time base after reset.
   localparam logic [23:0] ETC_RAW_RST    = 24'h000064;  // Raw multiplier after reset.
   localparam logic [23:0] ETC_AUTO_RST   = 24'h000000;  // Auto value after reset.
   localparam logic [23:0] ETC_ABS_RST    = 24'h0007D0;  // Readback after reset, raw times base.

   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int          ETC_CLK_NS     = 40;      // Clock period.
   localparam int          ETC_TICK_NS    = 1000;    // One microsecond.
   localparam int          ETC_TICK_CYC   = (ETC_TICK_NS + ETC_CLK_NS - 1) / ETC_CLK_NS;
   localparam logic [4:0]  ETC_TICK_LAST  = 5'(ETC_TICK_CYC - 1);
   localparam int          ETC_DIV_CYC    = 25;      // Divider steps, one per quotient bit.
endpackage

/* logic/etc_div.sv */
`timescale 1ns/10ps
// Restoring divider, one quotient bit per enabled clock.
module etc_div
   import etc_pkg::*;
(
   input  wire logic        pclk,      // Clock.
   input  wire logic        presetn,   // Asynchronous reset, active low.
   input  wire logic        ce,        // Clock enable.
   input  wire logic        start,     // Start pulse.
   input  wire logic [24:0] dividend,  // Numerator.
   input  wire logic [23:0] divisor,   // Denominator, never zero.
   output logic             busy,      // Division running.
   output logic             done,      // One-cycle result pulse.
   output logic [24:0]      quot       // Quotient.
);
   logic [24:0] num_reg;   // Shifting numerator, becomes quotient.
   logic [24:0] rem_reg;   // Partial remainder.
   logic [4:0]  step_reg;  // Steps left.
   logic [24:0] trial;     // Remainder after shift.

   // ----------------------------------------------------------------
   // Iteration.
   // ----------------------------------------------------------------
   assign trial = {rem_reg[23:0], num_reg[24]};
   assign quot  = num_reg;

   // Shift, subtract and keep the bit; the loop is short enough that a
   // combinational divider was not worth its area.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         num_reg  <= '0;
         rem_reg  <= '0;
         step_reg <= '0;
         busy     <= 1'b0;
         done     <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start && !busy) begin
            num_reg  <= dividend;
            rem_reg  <= '0;
            step_reg <= 5'(ETC_DIV_CYC);
            busy     <= 1'b1;
         end else if (busy) begin
            if (trial >= {1'b0, divisor}) begin
               rem_reg <= trial - {1'b0, divisor};
               num_reg <= {num_reg[23:0], 1'b1};
            end else begin
               rem_reg <= trial;
               num_reg <= {num_reg[23:0], 1'b0};
            end
            step_reg <= step_reg - 5'h01;
            if (step_reg == 5'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // etc_div

/* test/etc_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module testbench
   import etc_pkg::*;
;
   logic        pclk = 0, presetn = 0, ce = 1;   // Clock, reset, enable.
   logic        psel = 0, penable = 0, pwrite = 0; // APB controls.
   logic [7:0]  paddr = 8'h00;                   // APB address.
   logic [31:0] pwdata = 32'h0, prdata;          // APB data.
   logic        pready, pslverr, expo;           // Answers.
   logic        trigger_pin = 0;                 // Trigger pin.
   int          error_cnt = 0, n_tests = 0, cyc = 0; // Counters.
   logic [31:0] rv;                              // Last read data.
   logic        re;                              // Last error flag.
   // -------------------------------------------------------------
   // Short-variant instance so the cap sits below 10000000.
   // -------------------------------------------------------------
   etc_top #(.MAX_US(24'h0F4240), .MIN_US(24'h000018)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin), .exposure_active(expo));
   initial begin
      forever #20 pclk = ~pclk;
   end
   // Watchdog; a hang counts as a mismatch.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude();
      if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One APB transfer; the answer is taken at the rising edge that shows
   // pready high, and only then is the request released.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
      apb(0, a, 32'h0);
      `CHK(nm, ex, rv)
   endtask
   // Poll until the conversion is finished; the watchdog bounds the wait.
   task automatic idle();
      do begin
         apb(1'b0, ETC_OFS_STATUS, 32'h0);
      end while (rv[ETC_ST_BUSY] !== 1'b0);
   endtask
   // Cycles for which the exposure output stands after a start write.
   task automatic expo_len(output int n);
      n = 0;
      @(posedge pclk);
      while (expo === 1'b1 && n < 1000) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic t_reset();
      rd(ETC_OFS_BASE, 32'h14, "base_rst");
      rd(ETC_OFS_RAW, 32'h64, "raw_rst");
      rd(ETC_OFS_ABS, 32'h7D0, "abs_rst");
   endtask
   // Every duration programmed here stays at or above the 24 us minimum.
   task automatic t_raw_base();
      apb(1, ETC_OFS_RAW, 32'h7);
      rd(ETC_OFS_ABS, 32'h8C, "abs_raw");
      apb(1, ETC_OFS_BASE, 32'h4);
      rd(ETC_OFS_ABS, 32'h1C, "abs_base");
   endtask
   // Absolute writes at base 62: exact, round down, round up, fine base.
   task automatic t_abs();
      apb(1, ETC_OFS_BASE, 32'h3E);
      apb(1, ETC_OFS_ABS, 32'h7C);
      apb(1, ETC_OFS_ABS, 32'h96);
      `CHK("abs_busy", 1'b1, re)
      idle();
      rd(ETC_OFS_RAW, 32'h2, "raw_abs");
      apb(1, ETC_OFS_ABS, 32'h96);
      idle();
      rd(ETC_OFS_ABS, 32'h7C, "abs_dn");
      apb(1, ETC_OFS_ABS, 32'hA0);
      idle();
      rd(ETC_OFS_ABS, 32'hBA, "abs_up");
      apb(1, ETC_OFS_BASE, 32'h1);
      apb(1, ETC_OFS_ABS, 32'h25);
      idle();
      rd(ETC_OFS_ABS, 32'h25, "abs_fine");
   endtask
   task automatic t_limits();
      apb(1, ETC_OFS_RAW, 32'h989681);
      rd(ETC_OFS_RAW, 32'h989680, "raw_clamp");
      apb(1, ETC_OFS_BASE, 32'h989680);
      apb(1, ETC_OFS_RAW, 32'h1);
      rd(ETC_OFS_ABS, 32'h989680, "abs_long");
      apb(1, ETC_OFS_RAW, 32'h2);
      rd(ETC_OFS_ABS, 32'h0F4240, "abs_cap");
      apb(1, 8'h18, 32'h1);
      `CHK("unmapped", 1'b1, re)
      apb(1, ETC_OFS_STATUS, 32'h1);
      `CHK("status_wr", 1'b1, re)
   endtask
   // Auto value off the grid; auto dropped in pulse width mode.
   task automatic t_auto();
      apb(1, ETC_OFS_BASE, 32'h14);
      apb(1, ETC_OFS_AUTO, 32'h3039);
      rd(ETC_OFS_AUTO, 32'h3039, "auto_val");
      apb(1, ETC_OFS_CTRL, 32'h4);
      apb(0, ETC_OFS_STATUS, 0);
      `CHK("auto_on", 1'b1, rv[ETC_ST_AUTO])
      apb(1, ETC_OFS_CTRL, 32'h6);
      apb(0, ETC_OFS_STATUS, 0);
      `CHK("auto_off", 1'b0, rv[ETC_ST_AUTO])
      trigger_pin <= 1;
      repeat (10) @(posedge pclk);
      `CHK("pw_on", 1'b1, expo)
      trigger_pin <= 0;
      repeat (10) @(posedge pclk);
      `CHK("pw_off", 1'b0, expo)
   endtask
   // Timed exposures of 3 x 8 us on the raw path, then 30 us on the auto
   // path; the tick phase runs free, so the start may lose up to 1 us.
   task automatic t_expo();
      int n;
      apb(1, ETC_OFS_CTRL, 32'h0);
      apb(1, ETC_OFS_RAW, 32'h3);
      apb(1, ETC_OFS_BASE, 32'h8);
      apb(1, ETC_OFS_CTRL, 32'h1);
      expo_len(n);
      `CHK("expo_len", 1'b1, (n > 23 * ETC_TICK_CYC && n <= 24 * ETC_TICK_CYC))
      apb(1, ETC_OFS_AUTO, 32'h1E);
      apb(1, ETC_OFS_CTRL, 32'h5);
      expo_len(n);
      `CHK("auto_len", 1'b1, (n > 29 * ETC_TICK_CYC && n <= 30 * ETC_TICK_CYC))
   endtask
   // Clock enable low freezes a running exposure, which then runs its full
   // length once the enable returns.
   task automatic t_ce();
      int n;
      apb(1, ETC_OFS_CTRL, 32'h1);
      ce <= 1'b0;
      repeat (1000) @(posedge pclk);
      `CHK("ce_hold", 1'b1, expo)
      ce <= 1'b1;
      expo_len(n);
      `CHK("ce_len", 1'b1, (n > 23 * ETC_TICK_CYC && n <= 24 * ETC_TICK_CYC))
   endtask
   // -------------------------------------------------------------
   // Main sequence.
   // -------------------------------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_raw_base();
      t_abs();
      t_limits();
      t_auto();
      t_expo();
      t_ce();
      conclude();
   end
endmodule // testbench
